// file: hw/out_pair_pkg.sv
// constants and types for the first output pair configuration bank
// assumes a byte-wide register port clocked by the device control clock
// How it works
// - bits 7-5 of the route register hold the output source, reset 1: 1 dac, 2 bypass, 3 both.
// - source 4 sends dac to the positive and the positive bypass input to the negative output.
// - routing 0 differential, 1 stereo single-ended, 2 mono positive only, 3 mono negative only.
// - routing 4 and 5 pseudo-differential with negative as common mode, 6 positive as it.
// - bit 1 of the route register picks the common-mode level, 0 after reset.
// - bit 0 of the route register is read-only zero and software writes only zero.
// - bits 7-6 of the drive register pick the positive drive strength, reset 0.
// - bits 5-3 of the drive register set the positive level, reset 4 meaning 0 dB.
// - bit 2 of the drive register picks negative bypass impedance, 0 is 4.4 kilo-ohm.
// - bit 1 of the drive register picks bypass input type, 0 differential, 1 single-ended.
// - bit 0 of the drive register picks dac bandwidth, 0 is 24 kHz, 1 is 96 kHz.
// - route register at 0x64, drive register at 0x65, both reset to 0x20.
package out_pair_pkg;
    localparam logic [7:0] ROUTE_ADDR = 8'h64;
    localparam logic [7:0] DRIVE_ADDR = 8'h65;
    localparam logic [7:0] ROUTE_RESET = 8'h20;
    localparam logic [7:0] DRIVE_RESET = 8'h20;
    localparam logic [7:0] ROUTE_WR_MASK = 8'hfe;
    localparam int SRC_LSB = 5;
    localparam int ROUTING_LSB = 2;
    localparam int VCOM_BIT = 1;
    localparam int DRIVE_LSB = 6;
    localparam int LEVEL_LSB = 3;
    localparam int IMP_BIT = 2;
    localparam int BYP_TYPE_BIT = 1;
    localparam int BW_BIT = 0;

    typedef enum logic [2:0] {
        SRC_RSVD0 = 3'h0, SRC_DAC = 3'h1, SRC_BYPASS = 3'h2, SRC_MIX = 3'h3,
        SRC_SPLIT_P = 3'h4, SRC_SPLIT_M = 3'h5, SRC_RSVD6 = 3'h6, SRC_RSVD7 = 3'h7
    } out_source_sel_t;

    typedef enum logic [2:0] {
        RT_DIFF = 3'h0, RT_STEREO_SE = 3'h1, RT_MONO_POS = 3'h2, RT_MONO_NEG = 3'h3,
        RT_PSEUDO_NEG = 3'h4, RT_PSEUDO_NEG_SENSE = 3'h5, RT_PSEUDO_POS = 3'h6,
        RT_RSVD7 = 3'h7
    } out_routing_sel_t;

    typedef enum logic [2:0] {
        LVL_RSVD0 = 3'h0, LVL_RSVD1 = 3'h1, LVL_P12 = 3'h2, LVL_P6 = 3'h3,
        LVL_0 = 3'h4, LVL_M6 = 3'h5, LVL_M12 = 3'h6, LVL_RSVD7 = 3'h7
    } pos_out_level_sel_t;

    // decoded controls for the analog output stage
    typedef struct packed {
        out_source_sel_t out_source_sel;
        out_routing_sel_t out_routing_sel;
        logic out_common_mode_sel;
        logic [1:0] pos_out_drive_sel;
        pos_out_level_sel_t pos_out_level_sel;
        logic neg_in_bypass_impedance;
        logic bypass_input_type;
        logic dac_pair_bandwidth_sel;
        logic dac_to_pos;
        logic dac_to_neg;
        logic byp_to_pos;
        logic byp_to_neg;
        logic pos_is_vcom;
        logic neg_is_vcom;
        logic ext_sense;
        logic cfg_reserved;
    } out_stage_ctrl_t;
endpackage

// file: hw/output_pair_route_config.sv
// register bank and decoder for the first output channel pair
// assumes single-cycle write and read strobes on the device control port
`timescale 1ns/1ps
`default_nettype none
module output_pair_route_config (
    input wire logic clk_sys, // device control clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [7:0] reg_addr, // register address
    input wire logic reg_wr_en, // write strobe, one cycle
    input wire logic [7:0] reg_wr_data, // write data
    input wire logic reg_rd_en, // read strobe, one cycle
    output logic [7:0] reg_rd_data, // read data, registered
    output logic reg_rd_valid, // read data valid, one cycle
    output out_pair_pkg::out_stage_ctrl_t stage_ctrl // controls to the output stage
);
    import out_pair_pkg::*;

    // ==========================================================
    // register storage
    logic [7:0] route_q;
    logic [7:0] route_d;
    logic [7:0] drive_q;
    logic [7:0] drive_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic rd_valid_q;
    out_stage_ctrl_t ctrl_q;
    out_stage_ctrl_t ctrl_d;

    wire hit_route = (reg_addr == ROUTE_ADDR);
    wire hit_drive = (reg_addr == DRIVE_ADDR);
    wire wr_route = reg_wr_en && hit_route;
    wire wr_drive = reg_wr_en && hit_drive;

    // reserved bit 0 never stores, so it always reads zero
    assign route_d = wr_route ? (reg_wr_data & ROUTE_WR_MASK) : route_q;
    assign drive_d = wr_drive ? reg_wr_data : drive_q;

    // unmapped addresses read as zero
    assign rd_data_d = hit_route ? route_q : (hit_drive ? drive_q : 8'h00);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            route_q <= ROUTE_RESET;
            drive_q <= DRIVE_RESET;
        end else begin
            route_q <= route_d;
            drive_q <= drive_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q <= reg_rd_en ? rd_data_d : rd_data_q;
            rd_valid_q <= reg_rd_en;
        end
    end

    assign reg_rd_data = rd_data_q;
    assign reg_rd_valid = rd_valid_q;

    // ==========================================================
    // field decode
    wire [2:0] src_d = route_d[SRC_LSB +: 3];
    wire [2:0] rt_d = route_d[ROUTING_LSB +: 3];
    wire [2:0] lvl_d = drive_d[LEVEL_LSB +: 3];
    wire src_split = (src_d == SRC_SPLIT_P) || (src_d == SRC_SPLIT_M);
    wire src_has_dac = (src_d == SRC_DAC) || (src_d == SRC_MIX);
    wire src_has_byp = (src_d == SRC_BYPASS) || (src_d == SRC_MIX);
    // routing is ignored under a split source, software must not rely on it
    wire rt_pos_vcom = !src_split && (rt_d == RT_PSEUDO_POS);
    wire rt_neg_vcom = !src_split && ((rt_d == RT_PSEUDO_NEG) || (rt_d == RT_PSEUDO_NEG_SENSE));
    wire rt_pos_used = !rt_pos_vcom && (rt_d != RT_MONO_NEG) && (rt_d != RT_RSVD7);
    wire rt_neg_used = !rt_neg_vcom && (rt_d != RT_MONO_POS) && (rt_d != RT_RSVD7);
    wire src_rsvd = (src_d == SRC_RSVD0) || (src_d == SRC_RSVD6) || (src_d == SRC_RSVD7);
    wire lvl_rsvd = (lvl_d == LVL_RSVD0) || (lvl_d == LVL_RSVD1) || (lvl_d == LVL_RSVD7);
    // level misuse is flagged only, the stage still receives the value
    wire lvl_misuse = ((lvl_d == LVL_P12) && (src_d != SRC_BYPASS))
        || (((lvl_d == LVL_P6) || (lvl_d == LVL_M6) || (lvl_d == LVL_M12)) && !src_has_byp)
        || ((lvl_d == LVL_M12) && drive_d[IMP_BIT]);

    always_comb begin
        ctrl_d = '0;
        ctrl_d.out_source_sel = out_source_sel_t'(src_d);
        ctrl_d.out_routing_sel = out_routing_sel_t'(rt_d);
        ctrl_d.out_common_mode_sel = route_d[VCOM_BIT];
        ctrl_d.pos_out_drive_sel = drive_d[DRIVE_LSB +: 2];
        ctrl_d.pos_out_level_sel = pos_out_level_sel_t'(lvl_d);
        ctrl_d.neg_in_bypass_impedance = drive_d[IMP_BIT];
        ctrl_d.bypass_input_type = drive_d[BYP_TYPE_BIT];
        ctrl_d.dac_pair_bandwidth_sel = drive_d[BW_BIT];
        ctrl_d.pos_is_vcom = rt_pos_vcom;
        ctrl_d.neg_is_vcom = rt_neg_vcom;
        ctrl_d.ext_sense = !src_split && (rt_d == RT_PSEUDO_NEG_SENSE);
        ctrl_d.cfg_reserved = src_rsvd || lvl_rsvd || lvl_misuse
            || (!src_split && (rt_d == RT_RSVD7));
        case (src_d)
            SRC_SPLIT_P: begin
                ctrl_d.dac_to_pos = 1'b1;
                ctrl_d.byp_to_neg = 1'b1;
            end
            SRC_SPLIT_M: begin
                ctrl_d.byp_to_pos = 1'b1;
                ctrl_d.dac_to_neg = 1'b1;
            end
            default: begin
                ctrl_d.dac_to_pos = src_has_dac && rt_pos_used;
                ctrl_d.dac_to_neg = src_has_dac && rt_neg_used;
                ctrl_d.byp_to_pos = src_has_byp && rt_pos_used;
                ctrl_d.byp_to_neg = src_has_byp && rt_neg_used;
            end
        endcase
    end

    // decoded from next-state values so controls track the registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= '0;
            ctrl_q.out_source_sel <= SRC_DAC;
            ctrl_q.pos_out_level_sel <= LVL_0;
            ctrl_q.dac_to_pos <= 1'b1;
            ctrl_q.dac_to_neg <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign stage_ctrl = ctrl_q;

    // ==========================================================
    // assertions
    property p_src_reset;
        @(posedge clk_sys) $fell(rst) |-> route_q[7:5] == 3'h1 && stage_ctrl.dac_to_pos;
    endproperty
    a_src_reset: assert property (p_src_reset) else $error("source not dac after reset");

    property p_split_p;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel == SRC_SPLIT_P |->
            stage_ctrl.dac_to_pos && stage_ctrl.byp_to_neg && !stage_ctrl.dac_to_neg;
    endproperty
    a_split_p: assert property (p_split_p) else $error("split 4 routed wrong");

    property p_split_m;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel == SRC_SPLIT_M |->
            stage_ctrl.byp_to_pos && stage_ctrl.dac_to_neg && !stage_ctrl.dac_to_pos;
    endproperty
    a_split_m: assert property (p_split_m) else $error("split 5 routed wrong");

    property p_mono_pos;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel == SRC_DAC && stage_ctrl.out_routing_sel == RT_MONO_POS
            |-> stage_ctrl.dac_to_pos && !stage_ctrl.dac_to_neg;
    endproperty
    a_mono_pos: assert property (p_mono_pos) else $error("mono positive routed wrong");

    property p_pseudo_pos;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel == SRC_BYPASS && stage_ctrl.out_routing_sel == RT_PSEUDO_POS
            |-> stage_ctrl.pos_is_vcom && !stage_ctrl.byp_to_pos && stage_ctrl.byp_to_neg;
    endproperty
    a_pseudo_pos: assert property (p_pseudo_pos) else $error("pseudo positive wrong");

    property p_vcom_follows;
        @(posedge clk_sys) disable iff (rst)
        wr_route |=> stage_ctrl.out_common_mode_sel == $past(reg_wr_data[1]);
    endproperty
    a_vcom_follows: assert property (p_vcom_follows) else $error("common mode not updated");

    property p_rsvd_zero;
        @(posedge clk_sys) disable iff (rst)
        reg_rd_en && hit_route |=> !reg_rd_data[0] && reg_rd_valid;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

    property p_drive_write;
        @(posedge clk_sys) disable iff (rst)
        wr_drive |=> stage_ctrl.pos_out_drive_sel == $past(reg_wr_data[7:6])
            && stage_ctrl.pos_out_level_sel == $past(reg_wr_data[5:3]);
    endproperty
    a_drive_write: assert property (p_drive_write) else $error("drive or level not taken");

    property p_low_bits;
        @(posedge clk_sys) disable iff (rst)
        wr_drive |=> {stage_ctrl.neg_in_bypass_impedance, stage_ctrl.bypass_input_type,
            stage_ctrl.dac_pair_bandwidth_sel} == $past(reg_wr_data[2:0]);
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("low drive bits not taken");

    property p_readback;
        @(posedge clk_sys) disable iff (rst)
        wr_drive ##1 (reg_rd_en && hit_drive && !reg_wr_en) |=> reg_rd_data == $past(reg_wr_data, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("drive register readback wrong");

    property p_reset_value;
        @(posedge clk_sys) $fell(rst) |-> route_q == 8'h20 && drive_q == 8'h20;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

    // ==========================================================
    // write path and read port
    property p_rt_fields;
        @(posedge clk_sys) disable iff (rst)
        wr_route |=> stage_ctrl.out_source_sel == $past(reg_wr_data[7:5])
            && stage_ctrl.out_routing_sel == $past(reg_wr_data[4:2]);
    endproperty
    a_rt_fields: assert property (p_rt_fields) else $error("route fields lost");

    property p_route_store;
        @(posedge clk_sys) disable iff (rst)
        wr_route |=> route_q == ($past(reg_wr_data) & ROUTE_WR_MASK);
    endproperty
    a_route_store: assert property (p_route_store) else $error("route not stored");

    property p_drive_store;
        @(posedge clk_sys) disable iff (rst)
        wr_drive |=> drive_q == $past(reg_wr_data);
    endproperty
    a_drive_store: assert property (p_drive_store) else $error("drive not stored");

    // controls move only on a write, so a stray address cannot glitch the stage
    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        !wr_route && !wr_drive |=> $stable(stage_ctrl);
    endproperty
    a_hold: assert property (p_hold) else $error("controls moved without a write");

    property p_unmapped_wr;
        @(posedge clk_sys) disable iff (rst)
        reg_wr_en && !hit_route && !hit_drive |=> $stable(route_q) && $stable(drive_q);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write stored");

    property p_rd_valid;
        @(posedge clk_sys) disable iff (rst)
        reg_rd_en |=> reg_rd_valid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");

    property p_rd_drop;
        @(posedge clk_sys) disable iff (rst)
        !reg_rd_en |=> !reg_rd_valid;
    endproperty
    a_rd_drop: assert property (p_rd_drop) else $error("read valid without read");

    // unmapped reads answer zero so software never sees a stale byte
    property p_unmapped_rd;
        @(posedge clk_sys) disable iff (rst)
        reg_rd_en && !hit_route && !hit_drive |=> reg_rd_data == 8'h00;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

    // ==========================================================
    // routing decode
    property p_mono_neg;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel == SRC_DAC && stage_ctrl.out_routing_sel == RT_MONO_NEG
            |-> stage_ctrl.dac_to_neg && !stage_ctrl.dac_to_pos;
    endproperty
    a_mono_neg: assert property (p_mono_neg) else $error("mono negative routed wrong");

    property p_stereo_byp;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel == SRC_BYPASS && stage_ctrl.out_routing_sel == RT_STEREO_SE
            |-> stage_ctrl.byp_to_pos && stage_ctrl.byp_to_neg && !stage_ctrl.dac_to_pos
            && !stage_ctrl.dac_to_neg;
    endproperty
    a_stereo_byp: assert property (p_stereo_byp) else $error("stereo bypass wrong");

    property p_mix_diff;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel == SRC_MIX && stage_ctrl.out_routing_sel == RT_DIFF
            |-> stage_ctrl.dac_to_pos && stage_ctrl.dac_to_neg && stage_ctrl.byp_to_pos
            && stage_ctrl.byp_to_neg && !stage_ctrl.pos_is_vcom && !stage_ctrl.neg_is_vcom;
    endproperty
    a_mix_diff: assert property (p_mix_diff) else $error("mix routed wrong");

    property p_pseudo_neg;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel == SRC_BYPASS && stage_ctrl.out_routing_sel == RT_PSEUDO_NEG
            |-> stage_ctrl.neg_is_vcom && stage_ctrl.byp_to_pos && !stage_ctrl.byp_to_neg
            && !stage_ctrl.ext_sense;
    endproperty
    a_pseudo_neg: assert property (p_pseudo_neg) else $error("pseudo negative wrong");

    property p_sense;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel == SRC_DAC && stage_ctrl.out_routing_sel == RT_PSEUDO_NEG_SENSE
            |-> stage_ctrl.ext_sense && stage_ctrl.neg_is_vcom && stage_ctrl.dac_to_pos
            && !stage_ctrl.dac_to_neg;
    endproperty
    a_sense: assert property (p_sense) else $error("external sense wrong");

    property p_split_vcom;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel inside {SRC_SPLIT_P, SRC_SPLIT_M}
            |-> !stage_ctrl.pos_is_vcom && !stage_ctrl.neg_is_vcom && !stage_ctrl.ext_sense;
    endproperty
    a_split_vcom: assert property (p_split_vcom) else $error("split source took routing");

    // a reserved source drives nothing, so no output gets a half-defined mix
    property p_rsvd_src;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.out_source_sel inside {SRC_RSVD0, SRC_RSVD6, SRC_RSVD7}
            |-> stage_ctrl.cfg_reserved && !stage_ctrl.dac_to_pos && !stage_ctrl.dac_to_neg
            && !stage_ctrl.byp_to_pos && !stage_ctrl.byp_to_neg;
    endproperty
    a_rsvd_src: assert property (p_rsvd_src) else $error("reserved source drove a path");

    property p_lvl_rsvd;
        @(posedge clk_sys) disable iff (rst)
        stage_ctrl.pos_out_level_sel inside {LVL_RSVD0, LVL_RSVD1, LVL_RSVD7}
            |-> stage_ctrl.cfg_reserved;
    endproperty
    a_lvl_rsvd: assert property (p_lvl_rsvd) else $error("reserved level not flagged");

    c_split: cover property (@(posedge clk_sys) stage_ctrl.out_source_sel == SRC_SPLIT_M);
    c_mix_diff: cover property (@(posedge clk_sys)
        stage_ctrl.out_source_sel == SRC_MIX && stage_ctrl.out_routing_sel == RT_DIFF);
    c_sense: cover property (@(posedge clk_sys) stage_ctrl.ext_sense);
    c_reserved: cover property (@(posedge clk_sys) stage_ctrl.cfg_reserved);
endmodule
`default_nettype wire

// file: testbench/output_pair_route_config_bench.sv
// self-checking bench for the output pair configuration bank
// assumes the bank alone, driven through its byte-wide register port at 200 MHz
`timescale 1ns/1ps
`default_nettype none
module output_pair_route_config_bench;
    import out_pair_pkg::*;
    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rback;
        logic [7:0] paths;
    } row_t;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_rd_data;
    logic reg_rd_valid;
    out_stage_ctrl_t stage_ctrl;
    int n_errors = 0;
    int checks_done = 0;
    row_t rows [20];
    logic [7:0] route_exp;
    logic [7:0] drive_exp;
    wire [14:0] fields_seen = {stage_ctrl.out_source_sel, stage_ctrl.out_routing_sel,
        stage_ctrl.out_common_mode_sel, stage_ctrl.pos_out_drive_sel,
        stage_ctrl.pos_out_level_sel, stage_ctrl.neg_in_bypass_impedance,
        stage_ctrl.bypass_input_type, stage_ctrl.dac_pair_bandwidth_sel};
    wire [7:0] paths_seen = {stage_ctrl.dac_to_pos, stage_ctrl.dac_to_neg, stage_ctrl.byp_to_pos,
        stage_ctrl.byp_to_neg, stage_ctrl.pos_is_vcom, stage_ctrl.neg_is_vcom, stage_ctrl.ext_sense,
        stage_ctrl.cfg_reserved};

    output_pair_route_config dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .stage_ctrl(stage_ctrl));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ==========================================
    // tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // entered 1 ns after an edge; the strobe lowers after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd_en = 1'b0;
        check("rd_valid", {15'h0, reg_rd_valid}, 16'h1);
        check("rd_data", {8'h0, reg_rd_data}, {8'h0, exp});
        @(posedge clk_sys);
        #1;
        check("rd_valid_drop", {15'h0, reg_rd_valid}, 16'h0);
    endtask

    // ==========================================
    // watchdog
    initial begin
        #5000;
        n_errors++;
        stop_test();
    end

    // ==========================================
    // main sequence
    initial begin
        // paths: dac_p dac_n byp_p byp_n p_vcom n_vcom sense reserved
        rows[0] = '{ROUTE_ADDR, 8'h20, 8'h20, 8'hc0};
        rows[1] = '{ROUTE_ADDR, 8'h47, 8'h46, 8'h30};
        rows[2] = '{ROUTE_ADDR, 8'h68, 8'h68, 8'ha0};
        rows[3] = '{ROUTE_ADDR, 8'h2c, 8'h2c, 8'h40};
        rows[4] = '{ROUTE_ADDR, 8'h50, 8'h50, 8'h24};
        rows[5] = '{ROUTE_ADDR, 8'h34, 8'h34, 8'h86};
        rows[6] = '{ROUTE_ADDR, 8'h78, 8'h78, 8'h58};
        rows[7] = '{ROUTE_ADDR, 8'h80, 8'h80, 8'h90};
        rows[8] = '{ROUTE_ADDR, 8'ha0, 8'ha0, 8'h60};
        rows[9] = '{ROUTE_ADDR, 8'h00, 8'h00, 8'h01};
        rows[10] = '{ROUTE_ADDR, 8'h5c, 8'h5c, 8'h01};
        rows[11] = '{ROUTE_ADDR, 8'h28, 8'h28, 8'h80};
        rows[12] = '{ROUTE_ADDR, 8'h58, 8'h58, 8'h18};
        rows[13] = '{ROUTE_ADDR, 8'h60, 8'h60, 8'hf0};
        // bypass-only source, so levels 2, 3 and 6 below are ones software may pick, 0 and 7 are reserved
        rows[14] = '{ROUTE_ADDR, 8'h40, 8'h40, 8'h30};
        rows[15] = '{DRIVE_ADDR, 8'hc7, 8'hc7, 8'h31};
        rows[16] = '{DRIVE_ADDR, 8'h5a, 8'h5a, 8'h30};
        rows[17] = '{DRIVE_ADDR, 8'h10, 8'h10, 8'h30};
        rows[18] = '{DRIVE_ADDR, 8'h32, 8'h32, 8'h30};
        rows[19] = '{DRIVE_ADDR, 8'h3a, 8'h3a, 8'h31};
        route_exp = 8'h20;
        drive_exp = 8'h20;
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        check("reset_fields", {1'b0, fields_seen}, {1'b0, route_exp[7:1], drive_exp});
        check("reset_paths", {8'h0, paths_seen}, 16'h00c0);
        rd(ROUTE_ADDR, 8'h20);
        rd(DRIVE_ADDR, 8'h20);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            if (rows[i].addr === ROUTE_ADDR) begin
                route_exp = rows[i].rback;
            end else begin
                drive_exp = rows[i].rback;
            end
            check("paths", {8'h0, paths_seen}, {8'h0, rows[i].paths});
            check("fields", {1'b0, fields_seen}, {1'b0, route_exp[7:1], drive_exp});
            rd(rows[i].addr, rows[i].rback);
        end
        // unmapped neighbours take nothing and read zero
        wr(8'h66, 8'hff);
        check("unmapped_wr", {1'b0, fields_seen}, {1'b0, route_exp[7:1], drive_exp});
        rd(8'h66, 8'h00);
        rd(8'h63, 8'h00);
        // write and read in the same cycle return the old value
        reg_addr = DRIVE_ADDR;
        reg_wr_data = 8'h81;
        reg_wr_en = 1'b1;
        reg_rd_en = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        check("same_cycle_rd", {8'h0, reg_rd_data}, {8'h0, drive_exp});
        drive_exp = 8'h81;
        check("same_cycle_wr", {1'b0, fields_seen}, {1'b0, route_exp[7:1], drive_exp});
        // reset again in mid-run
        rst = 1'b1;
        @(posedge clk_sys);
        #1;
        rst = 1'b0;
        check("rerst_fields", {1'b0, fields_seen}, 16'h1020);
        check("rerst_paths", {8'h0, paths_seen}, 16'h00c0);
        rd(ROUTE_ADDR, 8'h20);
        rd(DRIVE_ADDR, 8'h20);
        stop_test();
    end
endmodule
`default_nettype wire
